/* File: inc/mmbs_defines.vh */
`ifndef MMBS_DEFINES_VH
`define MMBS_DEFINES_VH

// Program counter and program memory geometry
`define MMBS_PC_W          13
`define MMBS_PWORD_W       14
`define MMBS_PC_MASK_8K    13'h1FFF
`define MMBS_PC_MASK_4K    13'h0FFF
`define MMBS_RESET_VEC     13'h0000
`define MMBS_INT_VEC       13'h0004

// Data memory geometry
`define MMBS_DADDR_W       9
`define MMBS_OFS_W         7
`define MMBS_OFS_LAST      7'h7F
`define MMBS_GPR_BASE      7'h20
`define MMBS_GPR_WORDS     384

// Status register bank select positions and reset value
`define MMBS_STAT_BSEL_HI  6
`define MMBS_STAT_BSEL_LO  5
`define MMBS_STAT_RESET    8'h18

// Special function register offsets in the mirrored core set
`define MMBS_SFR_INDIRECT  7'h00
`define MMBS_SFR_STATUS    7'h03
`define MMBS_SFR_POINTER   7'h04

`endif

/* File: verilog/mmbs_gpr_ram.v */
`timescale 1ns/10ps
`include "mmbs_defines.vh"

module mmbs_gpr_ram (
  clk,
  we,
  waddr,
  wdata,
  raddr,
  rdata
);
  input  wire       clk;
  input  wire       we;
  input  wire [8:0] waddr;
  input  wire [7:0] wdata;
  input  wire [8:0] raddr;
  output reg  [7:0] rdata;

  reg [7:0] mem [0:`MMBS_GPR_WORDS-1];

  // Static RAM with registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // mmbs_gpr_ram

/* File: verilog/mmbs_memmap.v */
`timescale 1ns/10ps
`include "mmbs_defines.vh"

// Operation
// - Thirteen-bit program counter addresses 8K words of 14 bits.
// - Large variant implements 8K words, small variant only 4K words.
// - Fetch above implemented size wraps into the implemented range.
// - Reset loads the program counter with address 0000h.
// - Taken interrupt redirects execution to address 0004h.
// - Status bits 6 and 5 select data bank 0 to 3 in direct form; indirect form uses status bit 7 and pointer bit 7.
// - Each bank spans offsets 00h to 7Fh, 128 bytes.
// - Special registers at low offsets, static RAM above them per bank.
// - Frequently used special registers alias to one physical register.
// - Separate program and data buses allow concurrent fetch and access.
// - Register file reached directly or through the indirect pointer.
module mmbs_memmap #(
  parameter SMALL_VARIANT = 0
) (
  clk,
  srst,
  pc_load,
  pc_load_val,
  pc_hold,
  int_take,
  fetch_addr,
  fetch_data,
  instr,
  d_dir_ofs,
  d_rd,
  d_wr,
  d_wdata,
  d_rdata,
  d_rvalid,
  d_addr,
  d_sfr_hit,
  bank_sel_hi,
  bank_sel_lo,
  pointer_out
);
  input  wire        clk;
  input  wire        srst;
  input  wire        pc_load;
  input  wire [12:0] pc_load_val;
  input  wire        pc_hold;
  input  wire        int_take;
  output reg  [12:0] fetch_addr;
  input  wire [13:0] fetch_data;
  output reg  [13:0] instr;
  input  wire [6:0]  d_dir_ofs;
  input  wire        d_rd;
  input  wire        d_wr;
  input  wire [7:0]  d_wdata;
  output reg  [7:0]  d_rdata;
  output reg         d_rvalid;
  output reg  [8:0]  d_addr;
  output reg         d_sfr_hit;
  output reg         bank_sel_hi;
  output reg         bank_sel_lo;
  output reg  [7:0]  pointer_out;

  localparam [12:0] PC_MASK = SMALL_VARIANT ? `MMBS_PC_MASK_4K : `MMBS_PC_MASK_8K;
  // RAM bytes in one bank: from the RAM base offset up to the last offset
  // Every bank has the same share, so the folded array has no holes
  localparam [8:0]  BANK_GPR = {2'b00, `MMBS_OFS_LAST} + 9'h001 - {2'b00, `MMBS_GPR_BASE};

  // Pipeline and core register state
  reg  [12:0] pc_reg;
  reg  [12:0] pc_next;
  reg  [7:0]  status_reg;
  reg  [7:0]  indirect_pointer_reg;
  reg         sfr_rd_reg;
  reg  [7:0]  sfr_data_reg;
  reg         rd_pend_reg;
  reg  [8:0]  ram_base;
  reg  [8:0]  ram_addr;
  reg  [7:0]  sfr_rd_mux;
  // Address decode nets
  wire [8:0]  eff_addr;
  wire [6:0]  eff_ofs;
  wire [6:0]  gpr_ofs;
  wire        is_indirect;
  wire        is_sfr;
  wire        status_wr;
  wire        pointer_wr;
  wire        ram_we;
  wire [7:0]  ram_rdata;

  // Program counter next value: interrupt beats a jump, wrap by masking
  always @* begin
    if (int_take) begin
      pc_next = `MMBS_INT_VEC;
    end else if (pc_load) begin
      pc_next = pc_load_val & PC_MASK;
    end else if (pc_hold) begin
      pc_next = pc_reg;
    end else begin
      pc_next = (pc_reg + 13'h0001) & PC_MASK;
    end
  end

  // Program counter and fetch path on their own bus
  always @(posedge clk) begin
    if (srst) begin
      pc_reg     <= `MMBS_RESET_VEC;
      fetch_addr <= `MMBS_RESET_VEC;
      instr      <= 14'h0000;
    end else begin
      pc_reg     <= pc_next;
      fetch_addr <= pc_next & PC_MASK;
      instr      <= fetch_data;
    end
  end

  // Direct form joins bank bits and offset; offset 00h goes through the pointer
  assign is_indirect = (d_dir_ofs == `MMBS_SFR_INDIRECT);
  assign eff_addr    = is_indirect
                       ? {status_reg[7], indirect_pointer_reg}
                       : {status_reg[`MMBS_STAT_BSEL_HI],
                          status_reg[`MMBS_STAT_BSEL_LO], d_dir_ofs};
  assign eff_ofs     = eff_addr[6:0];
  assign is_sfr      = (eff_ofs < `MMBS_GPR_BASE);
  // Core register writes decoded once, alike in every bank
  assign status_wr   = d_wr && is_sfr && (eff_ofs == `MMBS_SFR_STATUS);
  assign pointer_wr  = d_wr && is_sfr && (eff_ofs == `MMBS_SFR_POINTER);
  assign ram_we      = d_wr && !is_sfr;

  // Offset inside the bank's RAM part; special offsets park on the first byte
  // so the read port never indexes past the end of the array
  assign gpr_ofs     = is_sfr ? 7'h00 : (eff_ofs - `MMBS_GPR_BASE);

  // Start of each bank's share of the folded RAM array
  always @* begin
    case (eff_addr[8:7])
      2'b00: begin
        ram_base = 9'h000;
      end
      2'b01: begin
        ram_base = BANK_GPR;
      end
      2'b10: begin
        ram_base = {BANK_GPR[7:0], 1'b0};
      end
      2'b11: begin
        ram_base = BANK_GPR + {BANK_GPR[7:0], 1'b0};
      end
      default: begin
        ram_base = 9'h000;
      end
    endcase
  end

  // General RAM folds banks into one array of 384 bytes, no shared region
  always @* begin
    ram_addr = ram_base + {2'b00, gpr_ofs};
  end

  // Read port runs every cycle; only d_rvalid marks a word worth taking
  mmbs_gpr_ram u_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (ram_addr),
    .wdata (d_wdata),
    .raddr (ram_addr),
    .rdata (ram_rdata)
  );

  // Readback of the mirrored core registers; other special offsets read 00h
  always @* begin
    case (eff_ofs)
      `MMBS_SFR_STATUS: begin
        sfr_rd_mux = status_reg;
      end
      `MMBS_SFR_POINTER: begin
        sfr_rd_mux = indirect_pointer_reg;
      end
      default: begin
        sfr_rd_mux = 8'h00;
      end
    endcase
  end

  // Mirrored core registers: every bank alias hits one physical register
  always @(posedge clk) begin
    if (srst) begin
      status_reg           <= `MMBS_STAT_RESET;
      indirect_pointer_reg <= 8'h00;
      sfr_data_reg         <= 8'h00;
      sfr_rd_reg           <= 1'b0;
      rd_pend_reg          <= 1'b0;
    end else begin
      rd_pend_reg  <= d_rd;
      sfr_rd_reg   <= is_sfr;
      sfr_data_reg <= sfr_rd_mux;
      if (status_wr) begin
        status_reg <= d_wdata;
      end
      if (pointer_wr) begin
        indirect_pointer_reg <= d_wdata;
      end
    end
  end

  // Data bus outputs, all registered
  always @(posedge clk) begin
    if (srst) begin
      d_rdata     <= 8'h00;
      d_rvalid    <= 1'b0;
      d_addr      <= 9'h000;
      d_sfr_hit   <= 1'b0;
      bank_sel_hi <= 1'b0;
      bank_sel_lo <= 1'b0;
      pointer_out <= 8'h00;
    end else begin
      d_rvalid    <= rd_pend_reg;
      d_rdata     <= sfr_rd_reg ? sfr_data_reg : ram_rdata;
      d_addr      <= eff_addr;
      d_sfr_hit   <= is_sfr;
      bank_sel_hi <= status_reg[`MMBS_STAT_BSEL_HI];
      bank_sel_lo <= status_reg[`MMBS_STAT_BSEL_LO];
      pointer_out <= indirect_pointer_reg;
    end
  end
endmodule // mmbs_memmap

/* File: dv/mmbs_memmap_chk.sv */
`timescale 1ns/10ps
`include "mmbs_defines.vh"
// Watches program counter sequencing and data map outputs
module mmbs_memmap_chk #(
  parameter SMALL_VARIANT = 0
) (
  input wire        clk,
  input wire        srst,
  input wire        pc_load,
  input wire        int_take,
  input wire        pc_hold,
  input wire        d_rd,
  input wire        d_wr,
  input wire        d_rvalid,
  input wire        bank_sel_hi,
  input wire        bank_sel_lo,
  input wire [12:0] pc_load_val,
  input wire [12:0] fetch_addr,
  input wire [13:0] fetch_data,
  input wire [13:0] instr,
  input wire [6:0]  d_dir_ofs,
  input wire [7:0]  d_wdata,
  input wire [8:0]  d_addr
);
  // Wrap mask of the variant being watched
  localparam [12:0] PC_MASK = SMALL_VARIANT ? `MMBS_PC_MASK_4K : `MMBS_PC_MASK_8K;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Program counter
  a_pc_reset: assert property ($fell(srst) |-> fetch_addr == 13'h0000) else $error("pc");
  a_int_vector: assert property (int_take |=> fetch_addr == 13'h0004) else $error("iv");
  a_jump_load: assert property (pc_load && !int_take |=>
    fetch_addr == ($past(pc_load_val) & PC_MASK)) else $error("jump");
  a_pc_step: assert property (!(pc_load || int_take || pc_hold) |=>
    fetch_addr == (($past(fetch_addr) + 13'h0001) & PC_MASK)) else $error("step");
  a_fetch_pipe: assert property (1'b1 |=> instr == $past(fetch_data)) else $error("ir");
  // Data side
  a_rd_valid: assert property (d_rd |-> ##2 d_rvalid) else $error("rv");
  a_dir_addr: assert property (d_rd && d_dir_ofs != 7'h00 |=>
    d_addr == {bank_sel_hi, bank_sel_lo, $past(d_dir_ofs)}) else $error("da");
  a_bank_sel: assert property (d_wr && d_dir_ofs == 7'h03 |-> ##2
    {1'b0, bank_sel_hi, bank_sel_lo, 5'h00} == ($past(d_wdata, 2) & 8'h60)) else $error("bs");
endmodule // mmbs_memmap_chk

bind mmbs_memmap mmbs_memmap_chk #(
  .SMALL_VARIANT (SMALL_VARIANT)
) u_mmbs_memmap_chk (
  .clk         (clk),
  .srst        (srst),
  .pc_load     (pc_load),
  .int_take    (int_take),
  .pc_hold     (pc_hold),
  .d_rd        (d_rd),
  .d_wr        (d_wr),
  .d_rvalid    (d_rvalid),
  .bank_sel_hi (bank_sel_hi),
  .bank_sel_lo (bank_sel_lo),
  .pc_load_val (pc_load_val),
  .fetch_addr  (fetch_addr),
  .fetch_data  (fetch_data),
  .instr       (instr),
  .d_dir_ofs   (d_dir_ofs),
  .d_wdata     (d_wdata),
  .d_addr      (d_addr)
);

/* File: dv/mmbs_memmap_tb.sv */
`timescale 1ns/10ps
module mmbs_memmap_tb;
  reg         clk = 1'b0, srst = 1'b1, pc_load = 1'b0, pc_hold = 1'b0, int_take = 1'b0;
  reg         d_rd = 1'b0, d_wr = 1'b0;
  reg  [12:0] pc_load_val = 13'h0000;
  reg  [6:0]  d_dir_ofs = 7'h00;
  reg  [7:0]  d_wdata = 8'h00;
  reg  [16:0] rows [0:3];
  wire [13:0] fetch_data, instr;
  wire [12:0] fetch_addr;
  wire [12:0] small_fetch_addr;
  wire [8:0]  d_addr;
  wire [7:0]  d_rdata, pointer_out;
  wire        d_rvalid, d_sfr_hit, bank_sel_hi, bank_sel_lo;
  integer     error_cnt = 0, compares = 0, i;
  // Program memory answers each address with a word built from it
  assign fetch_data = {1'b1, fetch_addr};
  always #20 clk = ~clk;
  mmbs_memmap u_mmbs_memmap (
    .clk         (clk),
    .srst        (srst),
    .pc_load     (pc_load),
    .pc_load_val (pc_load_val),
    .pc_hold     (pc_hold),
    .int_take    (int_take),
    .fetch_addr  (fetch_addr),
    .fetch_data  (fetch_data),
    .instr       (instr),
    .d_dir_ofs   (d_dir_ofs),
    .d_rd        (d_rd),
    .d_wr        (d_wr),
    .d_wdata     (d_wdata),
    .d_rdata     (d_rdata),
    .d_rvalid    (d_rvalid),
    .d_addr      (d_addr),
    .d_sfr_hit   (d_sfr_hit),
    .bank_sel_hi (bank_sel_hi),
    .bank_sel_lo (bank_sel_lo),
    .pointer_out (pointer_out)
  );
  // Small variant beside it, watched for its program counter wrap
  mmbs_memmap #(
    .SMALL_VARIANT (1)
  ) u_mmbs_memmap_small (
    .clk         (clk),
    .srst        (srst),
    .pc_load     (pc_load),
    .pc_load_val (pc_load_val),
    .pc_hold     (pc_hold),
    .int_take    (int_take),
    .fetch_addr  (small_fetch_addr),
    .fetch_data  (fetch_data),
    .instr       (),
    .d_dir_ofs   (d_dir_ofs),
    .d_rd        (d_rd),
    .d_wr        (d_wr),
    .d_wdata     (d_wdata),
    .d_rdata     (),
    .d_rvalid    (),
    .d_addr      (),
    .d_sfr_hit   (),
    .bank_sel_hi (),
    .bank_sel_lo (),
    .pointer_out ()
  );
  // Compare and report
  task chk(input [12:0] got, input [12:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One data request held for one cycle; read data is up two edges on
  task acc(input wr, input [6:0] ofs, input [7:0] dat);
    @(posedge clk) #1;
    {d_wr, d_rd, d_dir_ofs, d_wdata} = {wr, !wr, ofs, dat};
    @(posedge clk) #1;
    {d_wr, d_rd} = 2'h0;
    @(posedge clk) #1;
  endtask
  task rd(input [6:0] ofs, input [7:0] exp);
    acc(1'b0, ofs, 8'h00);
    chk({4'h0, d_rvalid, d_rdata}, {5'h01, exp});
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog far beyond the hundred or so cycles of tests
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  // Rows: bank, offset, data; two banks share offset 70h on purpose
  initial begin
    rows[0] = {2'h0, 7'h25, 8'hA5};
    rows[1] = {2'h1, 7'h70, 8'h3C};
    rows[2] = {2'h2, 7'h45, 8'h5A};
    rows[3] = {2'h3, 7'h70, 8'hC3};
    repeat (5) @(posedge clk);
    #1 srst = 1'b0;
    rd(7'h03, 8'h18);
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, 7'h03, {1'b0, rows[i][16:15], 5'h00});
      acc(1'b1, rows[i][14:8], rows[i][7:0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, 7'h03, {1'b0, rows[i][16:15], 5'h00});
      rd(rows[i][14:8], rows[i][7:0]);
      chk({12'h000, d_sfr_hit}, 13'h0000);
    end
    rd(7'h03, 8'h60);
    $display("bank rows done");
    // Unwritable special register, then indirect read through the pointer
    acc(1'b1, 7'h10, 8'hFF);
    rd(7'h10, 8'h00);
    chk({12'h000, d_sfr_hit}, 13'h0001);
    acc(1'b1, 7'h03, 8'h00);
    acc(1'b1, 7'h04, 8'h25);
    chk({5'h00, pointer_out}, 13'h0025);
    rd(7'h00, 8'hA5);
    $display("special and indirect done");
    // Jump to the top, wrap, interrupt beating a jump, hold, reset
    {pc_load, pc_load_val} = {1'b1, 13'h1FFF};
    @(posedge clk) #1 pc_load = 1'b0;
    chk(fetch_addr, 13'h1FFF);
    chk(small_fetch_addr, 13'h0FFF);
    @(posedge clk) #1 {pc_load, int_take} = 2'h3;
    chk(fetch_addr, 13'h0000);
    chk(small_fetch_addr, 13'h0000);
    @(posedge clk) #1 {pc_load, int_take, pc_hold} = 3'h1;
    chk(fetch_addr, 13'h0004);
    repeat (2) @(posedge clk);
    #1 {pc_hold, srst} = 2'h1;
    chk(fetch_addr, 13'h0004);
    @(posedge clk) #1 srst = 1'b0;
    chk(fetch_addr, 13'h0000);
    rd(7'h03, 8'h18);
    $display("program counter done");
    end_of_test;
  end
endmodule // mmbs_memmap_tb
